// *** dv/srd_fetch_model.sv ***
// fetch-side model: offers queued instruction bytes to the decoder
`timescale 1ns/100ps
`default_nettype none
module srd_fetch_model
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // stream handshake
  input wire logic i_byte_ready,
  input wire logic [3:0] i_gap,
  output logic o_byte_valid,
  output logic [7:0] o_byte
);
  logic [7:0] q[$];
  logic [3:0] gap_r;
  // bench queues bytes away from the clock edge
  task send(input logic [7:0] b);
    q.push_back(b);
  endtask : send
  // byte held until taken; idle data toggles so no stale byte shows
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      q.delete();
      o_byte_valid <= 1'b0;
      o_byte <= 8'hA5;
      gap_r <= 4'h0;
    end
    else if (o_byte_valid && i_byte_ready && i_gap == 4'h0 && q.size() != 0)
      o_byte <= q.pop_front(); // prompt: next byte back to back
    else if (o_byte_valid && i_byte_ready)
    begin
      o_byte_valid <= 1'b0;
      o_byte <= ~o_byte;
      gap_r <= i_gap;
    end
    else if (!o_byte_valid && (gap_r != 4'h0 || q.size() == 0))
    begin
      o_byte <= ~o_byte;
      gap_r <= (gap_r == 4'h0) ? 4'h0 : gap_r - 4'h1;
    end
    else if (!o_byte_valid)
    begin
      o_byte_valid <= 1'b1;
      o_byte <= q.pop_front();
    end
  end
endmodule : srd_fetch_model
`default_nettype wire

// *** dv/tb_srd_decode.sv ***
// self-checking bench for the stack, rotate and string decoder
`timescale 1ns/100ps
`default_nettype none
module tb_srd_decode;
  import srd_pkg::*;
  typedef struct packed {
    logic [1:0] nb;
    logic [23:0] b;
    logic [2:0] md;
    logic [15:0] n;
    logic [4:0] op;
    logic [15:0] clk;
    logic [5:0] pfx, ob, ib, db;
  } srd_row_s;
  localparam logic [5:0] SK = 6'h3F;
  localparam logic [15:0] SKC = 16'hFFFF;
  logic i_clk_sys, i_reset, i_byte_valid, o_byte_ready, i_protected;
  logic i_io_slow, i_def_32, o_done, o_lock, o_rep, o_seg_valid, o_busy;
  logic [7:0] i_byte;
  logic [31:0] i_count_reg, cyc, take_cyc, n_errors, checks;
  logic [4:0] o_op;
  logic [2:0] o_seg;
  logic [5:0] o_opnd_bits, o_imm_bits, o_disp_bits;
  logic [15:0] o_clocks;
  logic [3:0] i_gap;
  // bytes, mode {prot,slow,def32}, n, class, clocks, prefixes, widths
  srd_row_s rows [0:40] = '{
    '{2'h1,24'h610000,3'h0,16'h0,5'h01,16'h6,6'h0,SK,SK,SK},
    '{2'h1,24'h610000,3'h4,16'h0,5'h01,16'h6,6'h0,SK,SK,SK},
    '{2'h1,24'h9C0000,3'h0,16'h0,5'h05,16'h2,6'h0,SK,SK,SK},
    '{2'h1,24'h9C0000,3'h4,16'h0,5'h05,16'h2,6'h0,SK,SK,SK},
    '{2'h1,24'h9D0000,3'h0,16'h0,5'h02,16'h9,6'h0,SK,SK,SK},
    '{2'h1,24'h9D0000,3'h4,16'h0,5'h02,16'h9,6'h0,SK,SK,SK},
    '{2'h1,24'h600000,3'h4,16'h0,5'h04,16'h6,6'h0,SK,SK,SK},
    '{2'h2,24'hFFF000,3'h0,16'h0,5'h03,16'h1,6'h0,SK,SK,6'h0},
    '{2'h1,24'h500000,3'h4,16'h0,5'h03,16'h1,6'h0,SK,6'h0,SK},
    '{2'h1,24'h1E0000,3'h0,16'h0,5'h03,16'h1,6'h0,SK,6'h0,SK},
    '{2'h2,24'h0FA000,3'h4,16'h0,5'h03,16'h1,6'h0,SK,SK,SK},
    '{2'h1,24'h680000,3'h0,16'h0,5'h03,16'h1,6'h0,SK,6'h10,SK},
    '{2'h1,24'h680000,3'h1,16'h0,5'h03,16'h1,6'h0,SK,6'h20,SK},
    '{2'h2,24'h666800,3'h0,16'h0,5'h03,16'h1,6'h0,SK,6'h20,SK},
    '{2'h1,24'h6A0000,3'h0,16'h0,5'h03,16'h1,6'h0,SK,6'h08,SK},
    '{2'h2,24'hD0D000,3'h0,16'h0,5'h06,16'h3,6'h0,6'h08,SK,SK},
    '{2'h2,24'hD3D000,3'h0,16'h0,5'h06,16'h8,6'h0,6'h10,SK,SK},
    '{2'h2,24'hC1D000,3'h4,16'h0,5'h06,16'h8,6'h0,SK,6'h08,SK},
    '{2'h2,24'hD1D800,3'h0,16'h0,5'h07,16'h4,6'h0,6'h10,SK,SK},
    '{2'h2,24'hD2D800,3'h4,16'h0,5'h07,16'h9,6'h0,6'h08,SK,SK},
    '{2'h2,24'hC0D800,3'h0,16'h0,5'h07,16'h9,6'h0,SK,6'h08,SK},
    '{2'h2,24'h0F3200,3'h0,16'h0,5'h08,SKC,6'h0,SK,SK,SK},
    '{2'h2,24'h0F3300,3'h4,16'h0,5'h09,SKC,6'h0,SK,SK,SK},
    '{2'h2,24'h0F3600,3'h0,16'h0,5'h0A,SKC,6'h0,SK,SK,SK},
    '{2'h2,24'h0F3100,3'h4,16'h0,5'h0B,SKC,6'h0,SK,SK,SK},
    '{2'h2,24'hF36C00,3'h0,16'h3,5'h0C,16'h1B,6'h10,6'h08,SK,SK},
    '{2'h2,24'hF36D00,3'h4,16'h2,5'h0C,16'h16,6'h10,6'h10,SK,SK},
    '{2'h2,24'hF36D00,3'h6,16'h2,5'h0C,16'h26,6'h10,6'h10,SK,SK},
    '{2'h2,24'hF3AD00,3'h1,16'h4,5'h0D,16'hE,6'h10,6'h20,SK,SK},
    '{2'h2,24'hF3A400,3'h0,16'h0,5'h0E,16'h9,6'h10,6'h08,SK,SK},
    '{2'h3,24'hF366A5,3'h0,16'h5,5'h0E,16'hE,6'h10,6'h20,SK,SK},
    '{2'h2,24'hF09C00,3'h0,16'h0,5'h05,16'h2,6'h20,SK,SK,SK},
    '{2'h2,24'h269C00,3'h0,16'h0,5'h05,16'h2,6'h08,SK,SK,SK},
    '{2'h2,24'h2E9C00,3'h0,16'h0,5'h05,16'h2,6'h09,SK,SK,SK},
    '{2'h2,24'h369C00,3'h0,16'h0,5'h05,16'h2,6'h0A,SK,SK,SK},
    '{2'h2,24'h3E9C00,3'h0,16'h0,5'h05,16'h2,6'h0B,SK,SK,SK},
    '{2'h2,24'h649C00,3'h0,16'h0,5'h05,16'h2,6'h0C,SK,SK,SK},
    '{2'h2,24'h659C00,3'h0,16'h0,5'h05,16'h2,6'h0D,SK,SK,SK},
    '{2'h2,24'hFF7000,3'h0,16'h0,5'h03,16'h1,6'h0,SK,SK,6'h08},
    '{2'h2,24'hFFB000,3'h0,16'h0,5'h03,16'h1,6'h0,SK,SK,6'h10},
    '{2'h3,24'h67FFB0,3'h0,16'h0,5'h03,16'h1,6'h0,SK,SK,6'h20}};

  srd_decode i_srd_decode (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_byte_valid(i_byte_valid), .i_byte(i_byte),
    .o_byte_ready(o_byte_ready), .i_protected(i_protected),
    .i_io_slow(i_io_slow), .i_def_32(i_def_32), .i_count_reg(i_count_reg),
    .o_done(o_done), .o_op(o_op), .o_lock(o_lock), .o_rep(o_rep),
    .o_seg(o_seg), .o_seg_valid(o_seg_valid), .o_opnd_bits(o_opnd_bits),
    .o_imm_bits(o_imm_bits), .o_disp_bits(o_disp_bits),
    .o_clocks(o_clocks), .o_busy(o_busy));
  srd_fetch_model i_srd_fetch_model (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_byte_ready(o_byte_ready), .i_gap(i_gap),
    .o_byte_valid(i_byte_valid), .o_byte(i_byte));

  task close_out();
    if (n_errors == 32'h0 && checks != 32'h0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks = checks + 32'h1;
    if (seen !== ex)
    begin
      n_errors = n_errors + 32'h1;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  // mode and count set on the edge, bytes queued off it
  task start(input srd_row_s r);
    @(posedge i_clk_sys);
    {i_protected, i_io_slow, i_def_32} <= r.md;
    i_count_reg <= {16'h0, r.n};
    @(negedge i_clk_sys);
    for (int k = 0; k < 3; k++)
      if (k < int'(r.nb))
        i_srd_fetch_model.send(r.b[23 - 8 * k -: 8]);
  endtask : start

  // wait for the end pulse, then compare what stands with it
  task finish(input srd_row_s r);
    int w;
    w = 0;
    while (o_done !== 1'b1 && w < 300)
    begin
      @(negedge i_clk_sys);
      w = w + 1;
    end
    chk("done", 32'(o_done), 32'h1);
    chk("class", 32'(o_op), 32'(r.op));
    chk("prefix", 32'({o_lock, o_rep, o_seg_valid, o_seg}), 32'(r.pfx));
    if (r.clk != SKC)
    begin
      chk("clocks", 32'(o_clocks), 32'(r.clk));
      chk("delay", cyc - take_cyc, 32'(r.clk) + 32'h1);
    end
    if (r.ob != SK)
      chk("opnd", 32'(o_opnd_bits), 32'(r.ob));
    if (r.ib != SK)
      chk("imm", 32'(o_imm_bits), 32'(r.ib));
    if (r.db != SK)
      chk("disp", 32'(o_disp_bits), 32'(r.db));
    @(negedge i_clk_sys);
  endtask : finish

  // free-running 25 MHz clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // cycle count, last byte taken, and the hang limit
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 32'h1;
    if (i_byte_valid && o_byte_ready && !i_reset)
      take_cyc <= cyc + 32'h1;
    if (cyc == 32'h1770)
    begin
      n_errors = n_errors + 32'h1;
      close_out();
    end
  end

  initial
  begin
    i_reset = 1'b1;
    {i_protected, i_io_slow, i_def_32} = 3'h0;
    i_count_reg = 32'h0;
    i_gap = 4'h0;
    cyc = 32'h0;
    take_cyc = 32'h0;
    n_errors = 32'h0;
    checks = 32'h0;
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (int i = 0; i <= 40; i++)
    begin
      start(rows[i]);
      finish(rows[i]);
    end
    // second opcode offered while busy must wait its turn
    start(rows[2]);
    start(rows[31]);
    start(rows[0]);
    finish(rows[2]);
    finish(rows[31]);
    finish(rows[0]);
    // slow fetch with gaps between the bytes of one instruction
    i_gap <= 4'h3;
    start(rows[30]);
    finish(rows[30]);
    i_gap <= 4'h0;
    // reset in the middle of a long string load
    start('{2'h2,24'hF3AD00,3'h0,16'h0100,5'h0D,16'h010A,6'h10,SK,SK,SK});
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b1;
    @(negedge i_clk_sys);
    chk("rst ready", 32'(o_byte_ready), 32'h1);
    chk("rst busy", 32'(o_busy), 32'h0);
    chk("rst class", 32'(o_op), 32'h0);
    chk("rst clocks", 32'(o_clocks), 32'h0);
    chk("rst rep", 32'(o_rep), 32'h0);
    @(posedge i_clk_sys);
    i_reset <= 1'b0;
    start(rows[4]);
    finish(rows[4]);
    close_out();
  end
endmodule : tb_srd_decode
`default_nettype wire

// *** rtl/srd_decode.sv ***
// instruction byte decoder with clock-count sequencer for the slice
`timescale 1ns/100ps
`default_nettype none
module srd_decode
  import srd_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // byte stream from fetch
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_byte_ready,
  // processor state
  input wire logic i_protected,
  input wire logic i_io_slow,
  input wire logic i_def_32,
  input wire logic [31:0] i_count_reg,
  // decode result
  output logic o_done,
  output logic [4:0] o_op,
  output logic o_lock,
  output logic o_rep,
  output logic [2:0] o_seg,
  output logic o_seg_valid,
  output logic [5:0] o_opnd_bits,
  output logic [5:0] o_imm_bits,
  output logic [5:0] o_disp_bits,
  output logic [15:0] o_clocks,
  output logic o_busy
);

  // one-hot sequencer states
  typedef enum logic [3:0]
  {
    ST_OPC = 4'h1, ST_ESC = 4'h2, ST_MODRM = 4'h4, ST_EXEC = 4'h8
  } srd_st_e;

  srd_st_e st_r, st_nxt;
  logic lock_r, lock_nxt, asz_r, asz_nxt, osz_r, osz_nxt;
  logic rep_r, rep_nxt, segv_r, segv_nxt;
  logic [2:0] seg_r, seg_nxt;
  logic [1:0] shk_r, shk_nxt;
  logic [15:0] cnt_r, cnt_nxt, clk_r, clk_nxt;
  logic [4:0] op_r, op_nxt;
  logic done_r, done_nxt, rdy_r, rdy_nxt, busy_r, busy_nxt;
  logic [5:0] ob_r, ob_nxt, ib_r, ib_nxt, db_r, db_nxt;
  logic [15:0] n16, t_clk;
  logic take;
  logic full32, addr32;

  assign take = i_byte_valid && rdy_r;
  assign full32 = i_def_32 ^ osz_r;
  assign addr32 = i_def_32 ^ asz_r;
  assign n16 = i_count_reg[15:0];

  // string timing uses count register at start as n
  always_comb
  begin
    t_clk = CLK_OTHER;
    case (op_r)
      SRD_INS: t_clk = (i_protected && i_io_slow ? CLK_INS_PBASE
        : CLK_INS_BASE) + 16'(CLK_INS_PER * n16);
      SRD_LODS: t_clk = CLK_LODS_BASE + n16;
      SRD_MOVS: t_clk = CLK_MOVS_BASE + n16;
      default: t_clk = CLK_OTHER;
    endcase
  end

  // byte-at-a-time decode, then count down the instruction clocks
  always_comb
  begin
    st_nxt = st_r;
    lock_nxt = lock_r;
    asz_nxt = asz_r;
    osz_nxt = osz_r;
    rep_nxt = rep_r;
    segv_nxt = segv_r;
    seg_nxt = seg_r;
    shk_nxt = shk_r;
    cnt_nxt = cnt_r;
    clk_nxt = clk_r;
    op_nxt = op_r;
    done_nxt = 1'b0;
    rdy_nxt = rdy_r;
    ob_nxt = ob_r;
    ib_nxt = ib_r;
    db_nxt = db_r;
    // old prefixes drop first, so a prefix taken this cycle still sticks
    if (done_r)
    begin
      lock_nxt = 1'b0;
      asz_nxt = 1'b0;
      osz_nxt = 1'b0;
      rep_nxt = 1'b0;
      segv_nxt = 1'b0;
      seg_nxt = 3'h0;
      clk_nxt = 16'h0000;
      ib_nxt = 6'h00;
    end
    case (st_r)
      ST_OPC:
      begin
        if (take)
        begin
          st_nxt = ST_EXEC;
          rdy_nxt = 1'b0;
          op_nxt = SRD_OTHER;
          cnt_nxt = CLK_OTHER;
          // prefixes stay pending for the next opcode
          if (i_byte == PFX_LOCK || i_byte == PFX_ASIZE
            || i_byte == PFX_OSIZE || i_byte == PFX_REP)
          begin
            lock_nxt = lock_nxt | (i_byte == PFX_LOCK);
            asz_nxt = asz_nxt | (i_byte == PFX_ASIZE);
            osz_nxt = osz_nxt | (i_byte == PFX_OSIZE);
            rep_nxt = rep_nxt | (i_byte == PFX_REP);
            st_nxt = ST_OPC;
            rdy_nxt = 1'b1;
          end
          else if (i_byte == PFX_ES || i_byte == PFX_CS || i_byte == PFX_SS
            || i_byte == PFX_DS || i_byte == PFX_FS || i_byte == PFX_GS)
          begin
            segv_nxt = 1'b1;
            st_nxt = ST_OPC;
            rdy_nxt = 1'b1;
            case (i_byte)
              PFX_ES: seg_nxt = 3'h0;
              PFX_CS: seg_nxt = 3'h1;
              PFX_SS: seg_nxt = 3'h2;
              PFX_DS: seg_nxt = 3'h3;
              PFX_FS: seg_nxt = 3'h4;
              default: seg_nxt = 3'h5;
            endcase
          end
          else if (i_byte == OP_POPALL)
          begin
            op_nxt = SRD_POPALL;
            cnt_nxt = CLK_POPALL;
          end
          else if (i_byte == OP_POPFLG)
          begin
            op_nxt = SRD_POPFLG;
            cnt_nxt = CLK_POPFLG;
          end
          else if (i_byte == OP_PUSHALL)
          begin
            op_nxt = SRD_PUSHALL;
            cnt_nxt = CLK_PUSHALL;
          end
          else if (i_byte == OP_PUSHFLG)
          begin
            op_nxt = SRD_PUSHFLG;
            cnt_nxt = CLK_PUSHFLG;
          end
          else if (i_byte[7:3] == OP_PUSHR_HI
            || (i_byte[7:5] == 3'h0 && i_byte[2:0] == REG_PUSH)
            || i_byte == 8'h68 || i_byte == 8'h6A)
          begin
            op_nxt = SRD_PUSH;
            cnt_nxt = CLK_PUSH;
            ib_nxt = i_byte == 8'h6A ? W_BYTE : 6'h00;
          end
          else if (i_byte == OP_ESC)
          begin
            st_nxt = ST_ESC;
            rdy_nxt = 1'b1;
          end
          else if (i_byte == OP_GRP5 || i_byte[7:1] == OP_SHF1_W
            || i_byte[7:1] == OP_SHFC_W || i_byte[7:1] == OP_SHFI_W)
          begin
            st_nxt = ST_MODRM;
            rdy_nxt = 1'b1;
            shk_nxt = i_byte == OP_GRP5 ? 2'h3 : (i_byte[7:1] == OP_SHF1_W
              ? 2'h0 : (i_byte[7:1] == OP_SHFC_W ? 2'h1 : 2'h2));
            if (i_byte[7:1] == OP_SHFI_W)
              ib_nxt = W_BYTE;
          end
          else if (rep_r && i_byte[7:1] == OP_INS_W)
            op_nxt = SRD_INS;
          else if (rep_r && i_byte[7:1] == OP_LODS_W)
            op_nxt = SRD_LODS;
          else if (rep_r && i_byte[7:1] == OP_MOVS_W)
            op_nxt = SRD_MOVS;
          // w bit picks byte or full size
          ob_nxt = i_byte[0] ? (full32 ? W_DWORD : W_WORD) : W_BYTE;
          db_nxt = 6'h00; // displacement only follows a modrm byte
          if (i_byte == 8'h68)
            ib_nxt = full32 ? W_DWORD : W_WORD;
        end
      end
      ST_ESC:
      begin
        if (take)
        begin
          st_nxt = ST_EXEC;
          rdy_nxt = 1'b0;
          cnt_nxt = CLK_OTHER;
          if (i_byte == OP2_MSR)
            op_nxt = SRD_MSR;
          else if (i_byte == OP2_PMC)
            op_nxt = SRD_PMC;
          else if (i_byte == OP2_SHR)
            op_nxt = SRD_SHR;
          else if (i_byte == OP2_TSC)
            op_nxt = SRD_TSC;
          else if (i_byte[7:6] == 2'h2 && i_byte[2:0] == 3'h0)
          begin
            op_nxt = SRD_PUSH;
            cnt_nxt = CLK_PUSH;
          end
          else
            op_nxt = SRD_OTHER;
        end
      end
      ST_MODRM:
      begin
        if (take)
        begin
          st_nxt = ST_EXEC;
          rdy_nxt = 1'b0;
          op_nxt = SRD_OTHER;
          cnt_nxt = CLK_OTHER;
          // short form for mod 01, full for mod 10; direct forms not decoded
          db_nxt = i_byte[7:6] == 2'h1 ? W_BYTE : (i_byte[7:6] == 2'h2
            ? (addr32 ? W_DWORD : W_WORD) : 6'h00);
          if (shk_r == 2'h3 && i_byte[5:3] == REG_PUSH)
          begin
            op_nxt = SRD_PUSH;
            cnt_nxt = CLK_PUSH;
          end
          else if (shk_r != 2'h3 && i_byte[5:3] == REG_RCL)
          begin
            op_nxt = SRD_RCL;
            cnt_nxt = shk_r == 2'h0 ? CLK_RCL1 : CLK_RCLN;
          end
          else if (shk_r != 2'h3 && i_byte[5:3] == REG_RCR)
          begin
            op_nxt = SRD_RCR;
            cnt_nxt = shk_r == 2'h0 ? CLK_RCR1 : CLK_RCRN;
          end
        end
      end
      ST_EXEC:
      begin
        // string counts resolve here, once the count register is known
        if (op_r == SRD_INS || op_r == SRD_LODS || op_r == SRD_MOVS)
        begin
          if (clk_r == 16'h0000)
          begin
            cnt_nxt = t_clk - 16'h0001;
            clk_nxt = t_clk;
          end
          else if (cnt_r != 16'h0000)
            cnt_nxt = cnt_r - 16'h0001;
        end
        else if (clk_r == 16'h0000)
        begin
          clk_nxt = cnt_r;
          cnt_nxt = cnt_r - 16'h0001;
        end
        else if (cnt_r != 16'h0000)
          cnt_nxt = cnt_r - 16'h0001;
        if (clk_r != 16'h0000 && cnt_r == 16'h0000)
        begin
          done_nxt = 1'b1;
          st_nxt = ST_OPC;
          rdy_nxt = 1'b1;
        end
      end
      default:
        st_nxt = ST_OPC;
    endcase
    // busy kept in its own flop so the pin has no gate behind it
    busy_nxt = ~rdy_nxt;
  end

  // state registers
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_r <= ST_OPC;
      lock_r <= 1'b0;
      asz_r <= 1'b0;
      osz_r <= 1'b0;
      rep_r <= 1'b0;
      segv_r <= 1'b0;
      seg_r <= 3'h0;
      shk_r <= 2'h0;
      cnt_r <= 16'h0000;
      clk_r <= 16'h0000;
      op_r <= 5'h00;
      done_r <= 1'b0;
      rdy_r <= 1'b1;
      busy_r <= 1'b0;
      ob_r <= 6'h00;
      ib_r <= 6'h00;
      db_r <= 6'h00;
    end
    else
    begin
      st_r <= st_nxt;
      lock_r <= lock_nxt;
      asz_r <= asz_nxt;
      osz_r <= osz_nxt;
      rep_r <= rep_nxt;
      segv_r <= segv_nxt;
      seg_r <= seg_nxt;
      shk_r <= shk_nxt;
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      op_r <= op_nxt;
      done_r <= done_nxt;
      rdy_r <= rdy_nxt;
      busy_r <= busy_nxt;
      ob_r <= ob_nxt;
      ib_r <= ib_nxt;
      db_r <= db_nxt;
    end
  end

  // outputs straight from flops
  assign o_byte_ready = rdy_r;
  assign o_done = done_r;
  assign o_op = op_r;
  assign o_lock = lock_r;
  assign o_rep = rep_r;
  assign o_seg = seg_r;
  assign o_seg_valid = segv_r;
  assign o_opnd_bits = ob_r;
  assign o_imm_bits = ib_r;
  assign o_disp_bits = db_r;
  assign o_clocks = clk_r;
  assign o_busy = busy_r;

  // pop-all spans exactly its clock count
  a_popall_time: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(o_busy) && op_nxt == SRD_POPALL |-> ##1 !o_done [*6] ##1 o_done)
    else $error("pop all length wrong");
  a_popflg_time: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_done && op_r == SRD_POPFLG |-> o_clocks == 16'h0009)
    else $error("pop flags count wrong");
  a_push_time: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_done && op_r == SRD_PUSH |-> o_clocks == 16'h0001)
    else $error("push count wrong");
  a_pushall_time: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_done && op_r == SRD_PUSHALL |-> o_clocks == 16'h0006)
    else $error("push all count wrong");
  a_pushflg_time: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_done && op_r == SRD_PUSHFLG |-> o_clocks == 16'h0002)
    else $error("push flags count wrong");
  a_rcl_time: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_done && op_r == SRD_RCL |-> o_clocks inside {16'h0003, 16'h0008})
    else $error("rotate left count wrong");
  a_rcr_time: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_done && op_r == SRD_RCR |-> o_clocks inside {16'h0004, 16'h0009})
    else $error("rotate right count wrong");
  a_prefix_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_done && !take |=> !o_lock && !o_rep && !o_seg_valid)
    else $error("prefix outlived instruction");
  a_tsc_decode: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    st_r == ST_ESC && take && i_byte == OP2_TSC |=> o_op == SRD_TSC)
    else $error("time stamp read missed");
endmodule : srd_decode
`default_nettype wire

// *** rtl/srd_pkg.sv ***
// constants for the stack, rotate and string slice decoder
package srd_pkg;
  // prefix bytes
  localparam logic [7:0] PFX_LOCK = 8'hF0;
  localparam logic [7:0] PFX_ASIZE = 8'h67;
  localparam logic [7:0] PFX_OSIZE = 8'h66;
  localparam logic [7:0] PFX_REP = 8'hF3;
  localparam logic [7:0] PFX_CS = 8'h2E;
  localparam logic [7:0] PFX_DS = 8'h3E;
  localparam logic [7:0] PFX_ES = 8'h26;
  localparam logic [7:0] PFX_FS = 8'h64;
  localparam logic [7:0] PFX_GS = 8'h65;
  localparam logic [7:0] PFX_SS = 8'h36;
  // single-byte opcodes and modrm reg fields
  localparam logic [7:0] OP_POPALL = 8'h61;
  localparam logic [7:0] OP_POPFLG = 8'h9D;
  localparam logic [7:0] OP_PUSHALL = 8'h60;
  localparam logic [7:0] OP_PUSHFLG = 8'h9C;
  localparam logic [7:0] OP_GRP5 = 8'hFF;
  localparam logic [7:0] OP_ESC = 8'h0F;
  localparam logic [6:0] OP_INS_W = 7'h36;
  localparam logic [6:0] OP_LODS_W = 7'h56;
  localparam logic [6:0] OP_MOVS_W = 7'h52;
  localparam logic [6:0] OP_SHF1_W = 7'h68;
  localparam logic [6:0] OP_SHFC_W = 7'h69;
  localparam logic [6:0] OP_SHFI_W = 7'h60;
  localparam logic [4:0] OP_PUSHR_HI = 5'h0A;
  localparam logic [2:0] REG_PUSH = 3'h6;
  localparam logic [2:0] REG_RCL = 3'h2;
  localparam logic [2:0] REG_RCR = 3'h3;
  // second bytes after 0F
  localparam logic [7:0] OP2_MSR = 8'h32;
  localparam logic [7:0] OP2_PMC = 8'h33;
  localparam logic [7:0] OP2_SHR = 8'h36;
  localparam logic [7:0] OP2_TSC = 8'h31;
  // clock counts
  localparam logic [15:0] CLK_POPALL = 16'h0006;
  localparam logic [15:0] CLK_POPFLG = 16'h0009;
  localparam logic [15:0] CLK_PUSH = 16'h0001;
  localparam logic [15:0] CLK_PUSHALL = 16'h0006;
  localparam logic [15:0] CLK_PUSHFLG = 16'h0002;
  localparam logic [15:0] CLK_RCL1 = 16'h0003;
  localparam logic [15:0] CLK_RCLN = 16'h0008;
  localparam logic [15:0] CLK_RCR1 = 16'h0004;
  localparam logic [15:0] CLK_RCRN = 16'h0009;
  localparam logic [15:0] CLK_INS_BASE = 16'h000C;
  localparam logic [15:0] CLK_INS_PBASE = 16'h001C;
  localparam logic [15:0] CLK_INS_PER = 16'h0005;
  localparam logic [15:0] CLK_LODS_BASE = 16'h000A;
  localparam logic [15:0] CLK_MOVS_BASE = 16'h0009;
  localparam logic [15:0] CLK_OTHER = 16'h0001;
  // operand widths in bits
  localparam logic [5:0] W_BYTE = 6'h08;
  localparam logic [5:0] W_WORD = 6'h10;
  localparam logic [5:0] W_DWORD = 6'h20;
  // decoded operation classes
  typedef enum logic [4:0]
  {
    SRD_NONE = 5'h00, SRD_POPALL = 5'h01, SRD_POPFLG = 5'h02,
    SRD_PUSH = 5'h03, SRD_PUSHALL = 5'h04, SRD_PUSHFLG = 5'h05,
    SRD_RCL = 5'h06, SRD_RCR = 5'h07, SRD_MSR = 5'h08, SRD_PMC = 5'h09,
    SRD_SHR = 5'h0A, SRD_TSC = 5'h0B, SRD_INS = 5'h0C, SRD_LODS = 5'h0D,
    SRD_MOVS = 5'h0E, SRD_OTHER = 5'h0F
  } srd_op_e;
endpackage : srd_pkg
